/* File: verilog/sclk_gen_pkg.sv */
// Purpose: shared constants for the sample-clock generator control block
// Assumes: 16-bit control words, 5-bit control register address
// Notes: offsets are control register numbers as seen in the frame slots
package sclk_gen_pkg;
    // Register numbers
    localparam logic [4:0] GEN1_MODE_OFFSET = 5'h10;
    localparam logic [4:0] GEN1_RATE_WORD_OFFSET = 5'h11;
    localparam logic [4:0] GEN1_PHASE_OFFSET = 5'h12;
    localparam logic [4:0] GEN2_MODE_OFFSET = 5'h13;

    // Reset values
    localparam logic [15:0] GEN1_MODE_RESET = 16'h00ff;
    localparam logic [15:0] GEN1_RATE_WORD_RESET = 16'hbb80;
    localparam logic [15:0] GEN1_PHASE_RESET = 16'h0000;
    localparam logic [15:0] GEN2_MODE_RESET = 16'h0000;

    // Mode register fields
    localparam int MODE_REF_BIT = 15;
    localparam int MODE_VID_BIT = 14;
    localparam int MODE_LOOP_GAIN_BIT = 13;
    localparam int MODE_BITCLK_PLUS_BIT = 12;
    localparam int MODE_EIGHT_SEVENTHS_BIT = 11;
    localparam int MODE_CONV_PIN_BIT = 10;
    localparam logic [15:0] MODE_WRITE_MASK = 16'hfcff;

    // Phase register fields
    localparam int PHASE_DIR_BIT = 8;
    localparam int PHASE_WIDTH = 9;
    localparam logic [15:0] PHASE_WRITE_MASK = 16'h01ff;

    // Rate modifier fields in video lock
    localparam int MOD_STD_BIT = 7;

    // Usable rate word range
    localparam logic [15:0] RATE_WORD_MIN = 16'h0fa0;
    localparam logic [15:0] RATE_WORD_MAX = 16'hd2f0;

    // Video lock base rates in Hz
    localparam logic [15:0] BASE_48000 = 16'hbb80;
    localparam logic [15:0] BASE_32000 = 16'h7d00;
    localparam logic [15:0] BASE_44100 = 16'hac44;
    localparam logic [15:0] BASE_29400 = 16'h72d8;
    localparam logic [15:0] BASE_44056 = 16'hac18;

    // Divisor support masks, bit i set means divide by i+1 allowed
    localparam logic [7:0] DIV_ALL = 8'hff;
    localparam logic [7:0] DIV_NO_3678 = 8'h1b;
    localparam logic [7:0] DIV_NO_7 = 8'hbf;

    // Phase drain timing
    localparam int SYS_CLK_HZ = 125000000;
    localparam int PHASE_DRAIN_HZ = 3072000;
    localparam int PHASE_DRAIN_CYCLES = (SYS_CLK_HZ / PHASE_DRAIN_HZ < 1) ? 1 : SYS_CLK_HZ / PHASE_DRAIN_HZ;

    // Echo sequencer
    typedef enum logic [1:0] {
        RB_IDLE = 2'b00,
        RB_WAIT_FRAME = 2'b01,
        RB_WAIT_SLOT1 = 2'b11
    } readback_state_t;
endpackage : sclk_gen_pkg

/* File: verilog/phase_ctl_if.sv */
// Purpose: bundle between the control block and the phase drain counter
// Assumes: one clock domain
// Notes: ctrl side loads and clears, drain side reports and steps
interface phase_ctl_if;
    logic load;
    logic [8:0] load_value;
    logic clear;
    logic suppress;
    logic [8:0] remaining;
    logic step_advance;
    logic step_retard;

    modport ctrl (output load, output load_value, output clear, output suppress,
                  input remaining, input step_advance, input step_retard);
    modport drain (input load, input load_value, input clear, input suppress,
                   output remaining, output step_advance, output step_retard);
endinterface : phase_ctl_if

/* File: verilog/phase_drain.sv */
// Purpose: holds pending phase shift and drains it one count per drain tick
// Assumes: sys_clk free running, resetn synchronous active low
// Notes: one step pulse per count consumed while suppress is low
module phase_drain import sclk_gen_pkg::*; #(
    parameter int DRAIN_CYCLES = PHASE_DRAIN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    phase_ctl_if.drain port
);
    localparam int TW = $clog2(DRAIN_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(DRAIN_CYCLES - 1);

    logic [TW-1:0] tick_q, tick_d;
    logic [8:0] pend_q, pend_d;
    logic adv_q, adv_d, ret_q, ret_d;
    logic tick;

    // Tick divider and pending count
    always_comb begin
        tick = (tick_q == TICK_LAST);
        tick_d = tick ? '0 : tick_q + TW'(1);
        pend_d = pend_q;
        adv_d = 1'b0;
        ret_d = 1'b0;
        if (port.clear) begin
            pend_d = '0;
        end else if (port.load) begin
            pend_d = port.load_value; // Replaces unfinished shift
        end else if (tick && pend_q[7:0] != 8'h00) begin
            pend_d = {pend_q[8], pend_q[7:0] - 8'h01};
            adv_d = !port.suppress && !pend_q[PHASE_DIR_BIT];
            ret_d = !port.suppress && pend_q[PHASE_DIR_BIT];
        end
        // Zero magnitude leaves the count idle, no further steps
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tick_q <= '0;
            pend_q <= '0;
            adv_q <= 1'b0;
            ret_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            pend_q <= pend_d;
            adv_q <= adv_d;
            ret_q <= ret_d;
        end
    end

    assign port.remaining = pend_q;
    assign port.step_advance = adv_q;
    assign port.step_retard = ret_q;
endmodule : phase_drain

/* File: verilog/video_rate_decode.sv */
// Purpose: decodes video lock rate modifiers into a conversion rate
// Assumes: modifiers as stored in a generator mode register
// Notes: combinational; caller registers the results
module video_rate_decode import sclk_gen_pkg::*; (
    input wire logic [7:0] modifiers,
    output logic [15:0] rate_hz,
    output logic combo_ok
);
    logic [15:0] base;
    logic [7:0] div_mask;
    logic base_ok;
    logic [3:0] div_code;

    // Base table by standard, then divisor check
    always_comb begin
        base = BASE_48000;
        div_mask = DIV_ALL;
        base_ok = 1'b1;
        div_code = modifiers[3:0];
        case ({modifiers[MOD_STD_BIT], modifiers[6:4]})
            4'h0: div_mask = DIV_NO_7; // NTSC 48000 lacks divide by 7
            4'h1: begin base = BASE_32000; div_mask = DIV_NO_3678; end
            4'h2: base = BASE_44100;
            4'h3: begin base = BASE_29400; div_mask = DIV_NO_3678; end
            4'h4: base = BASE_48000; // Needs raised sync rate
            4'h5: base = BASE_44056;
            4'h8: base = BASE_48000;
            4'h9: begin base = BASE_32000; div_mask = DIV_NO_3678; end
            4'ha: base = BASE_44100;
            4'hb: begin base = BASE_29400; div_mask = DIV_NO_3678; end
            default: base_ok = 1'b0;
        endcase
        combo_ok = base_ok && !div_code[3] && div_mask[div_code[2:0]];
        // Conversion clock is base over divisor
        rate_hz = combo_ok ? base / {12'h000, div_code + 4'h1} : 16'h0000;
    end
endmodule : video_rate_decode

/* File: verilog/sample_clock_generator_control.sv */
// Purpose: control registers and mode decode for sample-clock generators 1 and 2
// Assumes: host accesses arrive as one-cycle strobes decoded from frame slots
// Notes: slot strobes are one-cycle pulses synchronous to sys_clk
module sample_clock_generator_control import sclk_gen_pkg::*; #(
    parameter int DRAIN_CYCLES = PHASE_DRAIN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic power_down_pin_n,
    input wire logic gen1_enable,
    input wire logic bus_master,
    input wire logic slot0_start,
    input wire logic slot_timing_input,
    input wire logic slot1_start,
    input wire logic ctrl_wr_en,
    input wire logic ctrl_rd_en,
    input wire logic [4:0] ctrl_addr,
    input wire logic [15:0] ctrl_wdata,
    input wire logic [15:0] gen2_rate_word,
    output logic [15:0] echo_data,
    output logic echo_valid,
    output logic [15:0] gen1_mode,
    output logic [15:0] gen1_rate_word,
    output logic [16:0] gen1_conv_rate_hz,
    output logic gen1_rate_known,
    output logic gen1_rate_in_range,
    output logic gen1_bitclk_enable,
    output logic gen1_phase_advance,
    output logic gen1_phase_retard,
    output logic [8:0] gen1_phase_pending,
    output logic [15:0] gen2_mode,
    output logic [16:0] gen2_conv_rate_hz,
    output logic gen2_rate_known,
    output logic gen2_uses_sync,
    output logic gen2_video_lock_active,
    output logic gen2_phase_shift_allowed,
    output logic gen2_bitclk_enable
);
    // Rate with optional 8/7 stretch; widened so 8/7 of a full word fits
    function automatic logic [16:0] crystal_rate(input logic [15:0] word, input logic stretch);
        logic [19:0] scaled;
        scaled = {4'h0, word} << 3;
        scaled = scaled / 20'd7;
        crystal_rate = stretch ? scaled[16:0] : {1'b0, word};
    endfunction : crystal_rate

    logic regs_locked;
    logic phase_locked;
    logic frame_event;
    logic wr_gen1_mode, wr_gen1_rate, wr_gen1_phase, wr_gen2_mode;

    logic [15:0] gen1_mode_q, gen1_mode_d;
    logic [15:0] gen1_rate_q, gen1_rate_d;
    logic [15:0] gen2_mode_q, gen2_mode_d;
    logic [8:0] phase_snap_q, phase_snap_d;

    readback_state_t rb_state_q, rb_state_d;
    logic [15:0] rb_pend_q, rb_pend_d;
    logic [15:0] echo_data_q, echo_data_d;
    logic echo_valid_q, echo_valid_d;
    logic [15:0] access_value;

    logic [15:0] vid1_rate, vid2_rate;
    logic vid1_ok, vid2_ok;
    logic [16:0] g1_rate_q, g1_rate_d, g2_rate_q, g2_rate_d;
    logic g1_known_q, g1_known_d, g2_known_q, g2_known_d;
    logic g1_range_q, g1_range_d, g1_bitclk_q, g1_bitclk_d;
    logic g2_sync_q, g2_sync_d, g2_vid_q, g2_vid_d;
    logic g2_shift_q, g2_shift_d, g2_bitclk_q, g2_bitclk_d;

    phase_ctl_if pif();

    // Pin-driven holds; the phase register has the extra enable term
    assign regs_locked = !resetn || !power_down_pin_n;
    assign phase_locked = regs_locked || !gen1_enable;
    // Frame reference point depends on which end masters the port
    assign frame_event = bus_master ? slot0_start : slot_timing_input;

    // Write address decode
    always_comb begin
        wr_gen1_mode = 1'b0;
        wr_gen1_rate = 1'b0;
        wr_gen1_phase = 1'b0;
        wr_gen2_mode = 1'b0;
        if (ctrl_wr_en && ctrl_addr == GEN1_MODE_OFFSET) begin
            wr_gen1_mode = 1'b1;
        end else if (ctrl_wr_en && ctrl_addr == GEN1_RATE_WORD_OFFSET) begin
            wr_gen1_rate = 1'b1;
        end else if (ctrl_wr_en && ctrl_addr == GEN1_PHASE_OFFSET) begin
            wr_gen1_phase = 1'b1;
        end else if (ctrl_wr_en && ctrl_addr == GEN2_MODE_OFFSET) begin
            wr_gen2_mode = 1'b1;
        end
    end

    // Control registers; reserved bits are stored as zero
    always_comb begin
        gen1_mode_d = gen1_mode_q;
        gen1_rate_d = gen1_rate_q;
        gen2_mode_d = gen2_mode_q;
        phase_snap_d = phase_snap_q;
        if (regs_locked) begin
            gen1_mode_d = GEN1_MODE_RESET;
            gen1_rate_d = GEN1_RATE_WORD_RESET;
            gen2_mode_d = GEN2_MODE_RESET;
        end else begin
            if (wr_gen1_mode) begin
                gen1_mode_d = ctrl_wdata & MODE_WRITE_MASK;
            end
            if (wr_gen1_rate) begin
                gen1_rate_d = ctrl_wdata;
            end
            if (wr_gen2_mode) begin
                gen2_mode_d = ctrl_wdata & MODE_WRITE_MASK;
            end
        end
        if (phase_locked) begin
            phase_snap_d = GEN1_PHASE_RESET[8:0];
        end else if (frame_event) begin
            phase_snap_d = pif.remaining; // Pending shift as of frame start
        end
    end

    always_ff @(posedge sys_clk) begin
        gen1_mode_q <= gen1_mode_d;
        gen1_rate_q <= gen1_rate_d;
        gen2_mode_q <= gen2_mode_d;
        phase_snap_q <= phase_snap_d;
    end

    // Phase drain hookup; sync-referenced generator 1 cannot be shifted
    assign pif.load = wr_gen1_phase && !phase_locked;
    assign pif.load_value = ctrl_wdata[8:0] & PHASE_WRITE_MASK[8:0];
    assign pif.clear = phase_locked;
    assign pif.suppress = gen1_mode_q[MODE_REF_BIT];

    phase_drain #(
        .DRAIN_CYCLES(DRAIN_CYCLES)
    ) u_phase_drain (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .port(pif.drain)
    );

    // Value returned for an access: old contents on write, snapshot on phase read
    always_comb begin
        access_value = 16'h0000;
        if (ctrl_addr == GEN1_MODE_OFFSET) begin
            access_value = gen1_mode_q;
        end else if (ctrl_addr == GEN1_RATE_WORD_OFFSET) begin
            access_value = gen1_rate_q;
        end else if (ctrl_addr == GEN1_PHASE_OFFSET) begin
            access_value = ctrl_wr_en ? {7'h00, pif.remaining} : {7'h00, phase_snap_q};
        end else if (ctrl_addr == GEN2_MODE_OFFSET) begin
            access_value = gen2_mode_q;
        end
    end

    // Echo sequencer: wait for next frame, then slot 1
    always_comb begin
        rb_state_d = rb_state_q;
        rb_pend_d = rb_pend_q;
        echo_data_d = echo_data_q;
        echo_valid_d = 1'b0;
        if (ctrl_wr_en || ctrl_rd_en) begin
            rb_pend_d = access_value; // Contents just before the write
            rb_state_d = RB_WAIT_FRAME;
        end else begin
            case (rb_state_q)
                RB_IDLE: rb_state_d = RB_IDLE;
                RB_WAIT_FRAME: begin
                    if (frame_event) begin
                        rb_state_d = RB_WAIT_SLOT1;
                    end
                end
                RB_WAIT_SLOT1: begin
                    if (slot1_start) begin
                        echo_data_d = rb_pend_q;
                        echo_valid_d = 1'b1;
                        rb_state_d = RB_IDLE;
                    end
                end
                default: rb_state_d = RB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rb_state_q <= RB_IDLE;
            rb_pend_q <= 16'h0000;
            echo_data_q <= 16'h0000;
            echo_valid_q <= 1'b0;
        end else begin
            rb_state_q <= rb_state_d;
            rb_pend_q <= rb_pend_d;
            echo_data_q <= echo_data_d;
            echo_valid_q <= echo_valid_d;
        end
    end

    video_rate_decode u_gen1_video (
        .modifiers(gen1_mode_q[7:0]),
        .rate_hz(vid1_rate),
        .combo_ok(vid1_ok)
    );

    video_rate_decode u_gen2_video (
        .modifiers(gen2_mode_q[7:0]),
        .rate_hz(vid2_rate),
        .combo_ok(vid2_ok)
    );

    // Effective rates and generator modes; normal sync lock rate is unknown here
    always_comb begin
        g1_rate_d = 17'h00000;
        g1_known_d = 1'b0;
        g2_rate_d = 17'h00000;
        g2_known_d = 1'b0;
        if (!gen1_mode_q[MODE_REF_BIT]) begin
            g1_rate_d = crystal_rate(gen1_rate_q, gen1_mode_q[MODE_EIGHT_SEVENTHS_BIT]);
            g1_known_d = 1'b1;
        end else if (gen1_mode_q[MODE_VID_BIT]) begin
            g1_rate_d = {1'b0, vid1_rate};
            g1_known_d = vid1_ok;
        end
        // Lock-mode bit is only looked at when sync referenced
        if (!gen2_mode_q[MODE_REF_BIT]) begin
            g2_rate_d = crystal_rate(gen2_rate_word, gen2_mode_q[MODE_EIGHT_SEVENTHS_BIT]);
            g2_known_d = 1'b1;
        end else if (gen2_mode_q[MODE_VID_BIT]) begin
            g2_rate_d = {1'b0, vid2_rate}; // Modifiers give the rate
            g2_known_d = vid2_ok;
        end
        g1_range_d = gen1_rate_q >= RATE_WORD_MIN && gen1_rate_q <= RATE_WORD_MAX;
        g1_bitclk_d = !(gen1_mode_q[MODE_REF_BIT] && gen1_mode_q[MODE_VID_BIT]);
        g2_sync_d = gen2_mode_q[MODE_REF_BIT];
        g2_vid_d = gen2_mode_q[MODE_REF_BIT] && gen2_mode_q[MODE_VID_BIT];
        g2_shift_d = !gen2_mode_q[MODE_REF_BIT];
        g2_bitclk_d = !g2_vid_d; // No bit clock in video lock
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            g1_rate_q <= 17'h00000;
            g1_known_q <= 1'b0;
            g2_rate_q <= 17'h00000;
            g2_known_q <= 1'b0;
            g1_range_q <= 1'b0;
            g1_bitclk_q <= 1'b0;
            g2_sync_q <= 1'b0;
            g2_vid_q <= 1'b0;
            g2_shift_q <= 1'b0;
            g2_bitclk_q <= 1'b0;
        end else begin
            g1_rate_q <= g1_rate_d;
            g1_known_q <= g1_known_d;
            g2_rate_q <= g2_rate_d;
            g2_known_q <= g2_known_d;
            g1_range_q <= g1_range_d;
            g1_bitclk_q <= g1_bitclk_d;
            g2_sync_q <= g2_sync_d;
            g2_vid_q <= g2_vid_d;
            g2_shift_q <= g2_shift_d;
            g2_bitclk_q <= g2_bitclk_d;
        end
    end

    // Outputs
    assign echo_data = echo_data_q;
    assign echo_valid = echo_valid_q;
    assign gen1_mode = gen1_mode_q;
    assign gen1_rate_word = gen1_rate_q;
    assign gen1_conv_rate_hz = g1_rate_q;
    assign gen1_rate_known = g1_known_q;
    assign gen1_rate_in_range = g1_range_q;
    assign gen1_bitclk_enable = g1_bitclk_q;
    assign gen1_phase_advance = pif.step_advance;
    assign gen1_phase_retard = pif.step_retard;
    assign gen1_phase_pending = pif.remaining;
    assign gen2_mode = gen2_mode_q;
    assign gen2_conv_rate_hz = g2_rate_q;
    assign gen2_rate_known = g2_known_q;
    assign gen2_uses_sync = g2_sync_q;
    assign gen2_video_lock_active = g2_vid_q;
    assign gen2_phase_shift_allowed = g2_shift_q;
    assign gen2_bitclk_enable = g2_bitclk_q;
endmodule : sample_clock_generator_control

/* File: verif/host_frame_model.sv */
// Purpose: host-side frame timing for the control block's register port
// Assumes: one frame every FRAME clocks, pulses one cycle wide
// Notes: pulses move on the falling edge, clear of the sampling edge
module host_frame_model #(
    parameter int FRAME = 16
) (
    input wire logic sys_clk,
    output logic slot0_start = 1'b0,
    output logic slot_timing_input = 1'b0,
    output logic slot1_start = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // Slave timing pulse lags the master slot, so the two snapshot paths differ
    always @(negedge sys_clk) begin
        cnt <= (cnt + 1) % FRAME;
        slot0_start <= (cnt == 0);
        slot_timing_input <= (cnt == 2);
        slot1_start <= (cnt == 5);
    end
endmodule : host_frame_model

/* File: verif/sclk_ctl_asserts.sv */
// Purpose: port-level checks of the sample-clock generator control block
// Assumes: single clock, synchronous active-low reset
// Notes: derived outputs lag their register by one edge
module sclk_ctl_asserts import sclk_gen_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic power_down_pin_n,
    input wire logic gen1_enable,
    input wire logic slot1_start,
    input wire logic ctrl_wr_en,
    input wire logic [4:0] ctrl_addr,
    input wire logic [15:0] ctrl_wdata,
    input wire logic echo_valid,
    input wire logic [15:0] gen1_mode,
    input wire logic [15:0] gen1_rate_word,
    input wire logic gen1_phase_advance,
    input wire logic gen1_phase_retard,
    input wire logic [8:0] gen1_phase_pending,
    input wire logic [15:0] gen2_mode,
    input wire logic gen2_uses_sync,
    input wire logic gen2_video_lock_active,
    input wire logic gen2_phase_shift_allowed,
    input wire logic gen2_bitclk_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_mode_held: assert property (!power_down_pin_n |=> gen1_mode == GEN1_MODE_RESET)
        else $error("generator 1 mode left default in power-down");
    a_rate_held: assert property (!power_down_pin_n |=> gen1_rate_word == GEN1_RATE_WORD_RESET)
        else $error("rate word left default in power-down");
    a_rate_write: assert property (ctrl_wr_en && ctrl_addr == GEN1_RATE_WORD_OFFSET && power_down_pin_n
        |=> gen1_rate_word == $past(ctrl_wdata)) else $error("rate word write not stored");
    a_phase_load: assert property (ctrl_wr_en && ctrl_addr == GEN1_PHASE_OFFSET && power_down_pin_n
        && gen1_enable |=> gen1_phase_pending == $past(ctrl_wdata[8:0])) else $error("phase write not loaded");
    a_phase_cleared: assert property (!power_down_pin_n || !gen1_enable |=> gen1_phase_pending == 9'h000)
        else $error("phase register not cleared");
    // Without a write the count may only hold or drop by one
    a_drain_step: assert property (!ctrl_wr_en && power_down_pin_n && gen1_enable |=>
        gen1_phase_pending[7:0] == $past(gen1_phase_pending[7:0])
        || gen1_phase_pending[7:0] == $past(gen1_phase_pending[7:0]) - 8'h01) else $error("phase count jumped");
    a_idle_quiet: assert property (gen1_phase_pending[7:0] == 8'h00 [*3] |=>
        !gen1_phase_advance && !gen1_phase_retard) else $error("step pulse with no pending shift");
    a_echo_pulse: assert property (echo_valid |-> $past(slot1_start) ##1 !echo_valid)
        else $error("echo not a single pulse after slot 1");
    a_gen2_sync: assert property (gen2_mode[MODE_REF_BIT] |=> gen2_uses_sync && !gen2_phase_shift_allowed)
        else $error("generator 2 sync reference not applied");
    a_gen2_video: assert property (gen2_mode[MODE_REF_BIT] && gen2_mode[MODE_VID_BIT] |=>
        gen2_video_lock_active && !gen2_bitclk_enable) else $error("generator 2 video lock not applied");
endmodule : sclk_ctl_asserts

bind sample_clock_generator_control sclk_ctl_asserts i_sclk_ctl_asserts (.sys_clk, .resetn, .power_down_pin_n,
    .gen1_enable, .slot1_start, .ctrl_wr_en, .ctrl_addr, .ctrl_wdata, .echo_valid, .gen1_mode, .gen1_rate_word,
    .gen1_phase_advance, .gen1_phase_retard, .gen1_phase_pending, .gen2_mode, .gen2_uses_sync,
    .gen2_video_lock_active, .gen2_phase_shift_allowed, .gen2_bitclk_enable);

/* File: verif/sample_clock_generator_control_tb_top.sv */
// Purpose: self-checking bench for the sample-clock generator control block
// Assumes: inputs change on the falling edge, drain divider shortened to 4
// Notes: expected values worked out from the register and rate tables
module sample_clock_generator_control_tb_top import sclk_gen_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b1, resetn = 1'b0, power_down_pin_n = 1'b1, gen1_enable = 1'b1, bus_master = 1'b1;
    logic ctrl_wr_en = 1'b0, ctrl_rd_en = 1'b0, slot0_start, slot_timing_input, slot1_start, echo_valid;
    logic [4:0] ctrl_addr = 5'h00;
    logic [15:0] ctrl_wdata = 16'h0000, gen2_rate_word = 16'h7000, echo_data, gen1_mode, gen1_rate_word, gen2_mode, e;
    logic [16:0] gen1_conv_rate_hz, gen2_conv_rate_hz;
    logic [8:0] gen1_phase_pending;
    logic gen1_rate_known, gen1_rate_in_range, gen1_bitclk_enable, gen1_phase_advance, gen1_phase_retard;
    logic gen2_rate_known, gen2_uses_sync, gen2_video_lock_active, gen2_phase_shift_allowed, gen2_bitclk_enable;
    logic [21:0] g2_seen;
    int n_checks = 0, miscompares = 0, cycles = 0, adv_n = 0, ret_n = 0, b_adv, b_ret;
    // Video modifiers and {known, rate}; codes with no exact rate expect known clear and rate zero
    logic [7:0] vm [11] = '{8'h00, 8'h12, 8'h51, 8'h40, 8'hb0, 8'h96, 8'h06, 8'h84, 8'h23, 8'h60, 8'hc0};
    logic [17:0] vr [11] = '{18'h2bb80, 18'h00000, 18'h2560c, 18'h2bb80, 18'h272d8, 18'h00000, 18'h00000,
        18'h22580, 18'h22b11, 18'h00000, 18'h00000};
    logic [15:0] gm [3] = '{16'h8000, 16'hc080, 16'h0800};
    logic [21:0] g2 [3] = '{22'h240000, 22'h32bb80, 22'h0e8000};

    sample_clock_generator_control #(.DRAIN_CYCLES(4)) i_sample_clock_generator_control (.*);
    host_frame_model i_host_frame_model (.sys_clk, .slot0_start, .slot_timing_input, .slot1_start);

    assign g2_seen = {gen2_uses_sync, gen2_video_lock_active, gen2_phase_shift_allowed, gen2_bitclk_enable,
        gen2_rate_known, gen2_conv_rate_hz};

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Step tallies and hang guard; tests compare differences only
    always @(posedge sys_clk) begin
        adv_n <= adv_n + (gen1_phase_advance === 1'b1);
        ret_n <= ret_n + (gen1_phase_retard === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One access strobe, held over exactly one rising edge
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        ctrl_wr_en = wr;
        ctrl_rd_en = !wr;
        ctrl_addr = a;
        ctrl_wdata = d;
        @(negedge sys_clk);
        ctrl_wr_en = 1'b0;
        ctrl_rd_en = 1'b0;
    endtask : acc

    // Echo timing depends on frame position, so the wait is bounded, not fixed
    task automatic wait_echo(output logic [15:0] d);
        int i;
        for (i = 0; i < 80 && echo_valid !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        chk(echo_valid, 1'b1);
        d = echo_data;
        @(negedge sys_clk);
    endtask : wait_echo

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        chk(gen1_mode, 16'h00ff);
        chk(gen1_rate_word, 16'hbb80);
        chk(gen1_phase_pending, 9'h000);
        chk(gen2_mode, GEN2_MODE_RESET);
        $display("reset test done");
        acc(1'b1, GEN1_RATE_WORD_OFFSET, RATE_WORD_MAX);
        wait_echo(e);
        chk(e, 16'hbb80);
        chk(gen1_conv_rate_hz, {1'b0, RATE_WORD_MAX});
        chk(gen1_rate_in_range, 1'b1);
        bus_master = 1'b0;
        acc(1'b1, GEN1_RATE_WORD_OFFSET, RATE_WORD_MIN);
        wait_echo(e);
        chk(e, RATE_WORD_MAX);
        chk(gen1_conv_rate_hz, {1'b0, RATE_WORD_MIN});
        acc(1'b1, 5'h05, 16'h1234);
        wait_echo(e);
        chk(e, 16'h0000);
        $display("rate word test done");
        power_down_pin_n = 1'b0;
        acc(1'b1, GEN1_RATE_WORD_OFFSET, 16'h1f40);
        acc(1'b1, GEN1_MODE_OFFSET, 16'hc000);
        wait_echo(e);
        chk(e, 16'h00ff);
        chk(gen1_rate_word, 16'hbb80);
        chk(gen1_mode, 16'h00ff);
        power_down_pin_n = 1'b1;
        $display("power-down test done");
        for (int i = 0; i < 11; i++) begin
            acc(1'b1, GEN1_MODE_OFFSET, {8'hc0, vm[i]});
            wait_echo(e);
            chk({gen1_rate_known, gen1_conv_rate_hz}, vr[i]);
            chk(gen1_bitclk_enable, 1'b0);
        end
        $display("video lock test done");
        acc(1'b1, GEN1_MODE_OFFSET, 16'h00ff);
        wait_echo(e);
        chk(e, 16'hc0c0);
        chk(gen1_bitclk_enable, 1'b1);
        b_adv = adv_n;
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h0005);
        repeat (40) @(negedge sys_clk);
        chk(24'(adv_n - b_adv), 24'h000005);
        chk(gen1_phase_pending, 9'h000);
        b_ret = ret_n;
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h0103);
        repeat (40) @(negedge sys_clk);
        chk(24'(ret_n - b_ret), 24'h000003);
        b_ret = ret_n;
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h00ff);
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h0102);
        repeat (40) @(negedge sys_clk);
        chk(24'(ret_n - b_ret), 24'h000002);
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h00ff);
        wait_echo(e);
        acc(1'b0, GEN1_PHASE_OFFSET, 16'h0000);
        wait_echo(e);
        chk(e != 16'h0000 && e <= 16'h00ff, 1'b1);
        gen1_enable = 1'b0;
        acc(1'b1, GEN1_PHASE_OFFSET, 16'h0010);
        chk(gen1_phase_pending, 9'h000);
        gen1_enable = 1'b1;
        repeat (40) @(negedge sys_clk);
        chk(gen1_phase_pending, 9'h000);
        $display("phase test done");
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, GEN2_MODE_OFFSET, gm[i]);
            wait_echo(e);
            chk(g2_seen, g2[i]);
        end
        // Plain read returns the stored mode word
        acc(1'b0, GEN2_MODE_OFFSET, 16'h0000);
        wait_echo(e);
        chk(e, 16'h0800);
        $display("generator 2 test done");
        tally_and_finish();
    end
endmodule : sample_clock_generator_control_tb_top
